/* rtl/fsfc_counters.sv */
// Scaled retired and reference counters with read-only register port
`timescale 1ns/10ps
// How it works
// - Reference register is read-only 64 bits, scaled reference count in 55:0.
// - Bits 63:56 hold the class field, identical to the retired register's.
// - Retired counter adds the retired weight per retired instruction.
// - Reference counter adds weight times retire capacity every clock with clk_en high.
// - Both counters run on the core clock, so ratio ignores frequency.
// - Weights are fixed implementation constants, not absolute rates.
// - Retired weight is lab reference count; reference weight is compute-bound count.
// - Both weights are divided by one common power of two.
// - Counters run free and wrap modulo 2^56 back through zero.
// - Class field reads the frequency sensitivity monitor code, one.
// - Retired register is read-only, scaled retired count in 55:0.
module fsfc_counters
  import fsfc_pkg::*;
(
  input  wire logic                          clk,
  input  wire logic                          resetn,
  input  wire logic                          clk_en,
  input  wire logic [fsfc_pkg::RETIRE_W-1:0] retired_now,
  input  wire fsfc_pkg::fsfc_req_t           req,
  input  wire logic                          wr,
  output logic [fsfc_pkg::REG_W-1:0]         rd_data,
  output logic                               rd_valid,
  output logic                               rd_error
);
  import fsfc_pkg::*;

  logic [CNT_W-1:0] retired_q;
  logic [CNT_W-1:0] reference_q;
  logic [CNT_W-1:0] retired_d;
  logic [CNT_W-1:0] reference_d;
  fsfc_reg_t        reg_d;
  logic             hit_d;
  logic [1:0]       sel_d;

  ////////////////////////////////////////////////////////////////////////
  // Address match shared by the read path and the checks below
  // Bit 1 flags the reference register, bit 0 the retired register
  function automatic logic [1:0] fsfc_decode(input logic [31:0] addr);
    logic [1:0] hit;
    hit = 2'h0;
    if (addr == REFERENCE_ADDR)
      hit = 2'h2;
    else if (addr == RETIRED_ADDR)
      hit = 2'h1;
    return hit;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Weights come from package constants only; no register can change them
  always_comb
  begin
    retired_d   = retired_q + CNT_W'(RETIRED_INCREMENT_WEIGHT * CNT_W'(retired_now));
    reference_d = reference_q + CNT_W'(REFERENCE_INCREMENT_WEIGHT * CNT_W'(RETIRE_CAPACITY));
  end

  // Both counters on the one core clock; natural wrap at 2^56
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      retired_q   <= CNT_RESET;
      reference_q <= CNT_RESET;
    end
    else if (clk_en)
    begin
      retired_q   <= retired_d;
      reference_q <= reference_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read decode; writes are ignored so software cannot disturb counts
  always_comb
  begin
    reg_d.monitor_class_field = CLASS_FREQ_SENS;
    reg_d.count_field         = CNT_RESET;
    hit_d                     = 1'b1;
    sel_d                     = fsfc_decode(req.addr);
    if (sel_d[1])
      reg_d.count_field = reference_q;
    else if (sel_d[0])
      reg_d.count_field = retired_q;
    else
    begin
      hit_d                     = 1'b0;
      reg_d.monitor_class_field = 8'h00;
    end
  end

  // Snapshot from registered counters only, never mid-update
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      rd_data  <= 64'h0000000000000000;
      rd_valid <= 1'b0;
      rd_error <= 1'b0;
    end
    else if (clk_en)
    begin
      rd_valid <= req.rd;
      rd_error <= (req.rd && !hit_d) || (wr && hit_d);
      if (req.rd)
        rd_data <= reg_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checker-only tallies of enabled edges and retired instructions
  // 32 bits is plenty for any run and keeps the compare cheap
  logic [31:0] edge_tally_q;
  logic [31:0] retire_tally_q;

  // Tallies follow the same reset and enable as the counters
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      edge_tally_q   <= 32'h00000000;
      retire_tally_q <= 32'h00000000;
    end
    else if (clk_en)
    begin
      edge_tally_q   <= edge_tally_q + 32'h00000001;
      retire_tally_q <= retire_tally_q + 32'(retired_now);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // One enabled edge adds exactly weight times capacity
  reference_step_a: assert property (@(posedge clk) disable iff (!resetn)
    clk_en |=> reference_q == CNT_W'($past(reference_q) + REFERENCE_INCREMENT_WEIGHT * CNT_W'(RETIRE_CAPACITY)))
    else $error("reference counter step wrong");

  // One enabled edge adds weight times the instructions retired
  retired_step_a: assert property (@(posedge clk) disable iff (!resetn)
    clk_en |=> retired_q == CNT_W'($past(retired_q) + RETIRED_INCREMENT_WEIGHT * CNT_W'($past(retired_now))))
    else $error("retired counter step wrong");

  // Whole history: reference count is edges times the step
  reference_total_a: assert property (@(posedge clk) disable iff (!resetn)
    reference_q == CNT_W'(CNT_W'(edge_tally_q) * REFERENCE_INCREMENT_WEIGHT * CNT_W'(RETIRE_CAPACITY)))
    else $error("reference total wrong");

  // Whole history: retired count is instructions times the weight
  retired_total_a: assert property (@(posedge clk) disable iff (!resetn)
    retired_q == CNT_W'(CNT_W'(retire_tally_q) * RETIRED_INCREMENT_WEIGHT))
    else $error("retired total wrong");

  // A low enable must freeze both counts
  frozen_hold_a: assert property (@(posedge clk) disable iff (!resetn)
    !clk_en |=> $stable(retired_q) && $stable(reference_q))
    else $error("counters moved while disabled");

  // A low enable must freeze the read outputs too
  frozen_outputs_a: assert property (@(posedge clk) disable iff (!resetn)
    !clk_en |=> $stable(rd_valid) && $stable(rd_error) && $stable(rd_data))
    else $error("read outputs moved while disabled");

  // Every good answer carries the monitor class code
  class_code_a: assert property (@(posedge clk) disable iff (!resetn)
    rd_valid && !rd_error |-> rd_data[REG_W-1:CLASS_LSB] == CLASS_FREQ_SENS)
    else $error("class field wrong");

  // Reference read returns the count as it stood at the request edge
  reference_read_a: assert property (@(posedge clk) disable iff (!resetn)
    clk_en && req.rd && fsfc_decode(req.addr) == 2'h2 |=> rd_data[CNT_W-1:0] == $past(reference_q))
    else $error("reference read mismatch");

  // Retired read returns the count as it stood at the request edge
  retired_read_a: assert property (@(posedge clk) disable iff (!resetn)
    clk_en && req.rd && fsfc_decode(req.addr) == 2'h1 |=> rd_data[CNT_W-1:0] == $past(retired_q))
    else $error("retired read mismatch");

  // An unmapped read answers zero and flags the error
  unmapped_read_a: assert property (@(posedge clk) disable iff (!resetn)
    clk_en && req.rd && fsfc_decode(req.addr) == 2'h0 |=> rd_error && rd_data == 64'h0000000000000000)
    else $error("unmapped read not refused");

  // Writes must not disturb either count
  write_ignored_a: assert property (@(posedge clk) disable iff (!resetn)
    clk_en && wr |=> reference_q == CNT_W'($past(reference_q) + REFERENCE_INCREMENT_WEIGHT * CNT_W'(RETIRE_CAPACITY))
      && retired_q == CNT_W'($past(retired_q) + RETIRED_INCREMENT_WEIGHT * CNT_W'($past(retired_now))))
    else $error("write disturbed count");

  // A write to a mapped register is reported, never applied
  write_flag_a: assert property (@(posedge clk) disable iff (!resetn)
    clk_en && wr && fsfc_decode(req.addr) != 2'h0 |=> rd_error)
    else $error("mapped write not flagged");

  // Every enabled read is answered on the next edge
  read_valid_a: assert property (@(posedge clk) disable iff (!resetn)
    clk_en && req.rd |=> rd_valid)
    else $error("read not answered");

  // Valid is a pulse: no read, no answer
  valid_pulse_a: assert property (@(posedge clk) disable iff (!resetn)
    clk_en && !req.rd |=> !rd_valid)
    else $error("spurious read answer");

  // Read data holds between reads so software sees one snapshot
  data_hold_a: assert property (@(posedge clk) disable iff (!resetn)
    clk_en && !req.rd |=> $stable(rd_data))
    else $error("read data changed without a read");

  // Wrap only after the full 56-bit range; too slow to reach in a run
  wrap_free_a: assert property (@(posedge clk) disable iff (!resetn)
    clk_en && reference_q > reference_d |=> reference_q < $past(reference_q))
    else $error("wrap not taken");

  // Reset clears counts and answers; not gated by reset on purpose
  reset_clear_a: assert property (@(posedge clk)
    !resetn |=> reference_q == CNT_RESET && retired_q == CNT_RESET && !rd_valid && !rd_error)
    else $error("reset did not clear state");
endmodule // fsfc_counters

/* rtl/fsfc_pkg.sv */
// Package for the frequency sensitivity feedback counters
package fsfc_pkg;
  localparam int unsigned CNT_W             = 56;
  localparam int unsigned REG_W             = 64;
  localparam int unsigned CLASS_LSB         = 56;
  localparam int unsigned CLASS_W           = 8;
  localparam int unsigned RETIRE_W          = 3;
  localparam logic [31:0] RETIRED_ADDR      = 32'hC0010080;
  localparam logic [31:0] REFERENCE_ADDR    = 32'hC0010081;
  localparam logic [7:0]  CLASS_FREQ_SENS   = 8'h01;
  localparam logic [CNT_W-1:0] CNT_RESET    = 56'h00000000000000;
  // Lab-derived weights before the common divide
  localparam logic [31:0] RETIRED_WEIGHT_RAW   = 32'h00001000;
  localparam logic [31:0] REFERENCE_WEIGHT_RAW = 32'h00000C00;
  localparam int unsigned WEIGHT_SHIFT         = 4;
  localparam logic [RETIRE_W-1:0] RETIRE_CAPACITY = 3'h4;
  localparam logic [CNT_W-1:0] RETIRED_INCREMENT_WEIGHT   =
    CNT_W'(RETIRED_WEIGHT_RAW >> WEIGHT_SHIFT);
  localparam logic [CNT_W-1:0] REFERENCE_INCREMENT_WEIGHT =
    CNT_W'(REFERENCE_WEIGHT_RAW >> WEIGHT_SHIFT);

  typedef struct packed {
    logic [CLASS_W-1:0] monitor_class_field;
    logic [CNT_W-1:0]   count_field;
  } fsfc_reg_t;

  typedef struct packed {
    logic        rd;
    logic [31:0] addr;
  } fsfc_req_t;
endpackage

/* tb/fsfc_counters_tb_top.sv */
// Self-checking bench for the scaled feedback counters
`timescale 1ns/10ps
module fsfc_counters_tb_top;
  import fsfc_pkg::*;
  logic                clk, resetn, clk_en, wr, rd_valid, rd_error, e;
  logic [RETIRE_W-1:0] rate, retired_now;
  fsfc_req_t           req;
  logic [REG_W-1:0]    rd_data, a, b;
  int                  n_fail, n_checks;
  fsfc_counters uut (.clk(clk), .resetn(resetn), .clk_en(clk_en), .retired_now(retired_now), .req(req),
    .wr(wr), .rd_data(rd_data), .rd_valid(rd_valid), .rd_error(rd_error));
  fsfc_retire_model core (.rate(rate), .clk(clk), .resetn(resetn), .retired_now(retired_now));
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic results();
    $display("checks %0d failures %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [REG_W-1:0] got, input logic [REG_W-1:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // One access; pulse lasts one cycle, answer awaited under a bound
  task automatic acc(input logic [31:0] ad, input logic w, output logic [REG_W-1:0] d, output logic er);
    int i;
    @(negedge clk);
    req = '{rd: !w, addr: ad};
    wr = w;
    @(negedge clk);
    req.rd = 1'b0;
    wr = 1'b0;
    for (i = 0; i < 4 && rd_valid !== 1'b1 && rd_error !== 1'b1; i++) @(negedge clk);
    if (i == 4)
    begin
      n_fail++;
      results();
    end
    d = rd_data;
    er = rd_error;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Reads two edges apart, so each delta covers two increments; the delta across the write covers four
  initial
  begin
    {clk_en, wr, req, rate, resetn, n_fail, n_checks} = '0;
    clk_en = 1'b1;
    repeat (16) @(negedge clk);
    resetn = 1'b1;
    acc(REFERENCE_ADDR, 1'b0, a, e);
    chk(a[63:56], CLASS_FREQ_SENS);
    acc(REFERENCE_ADDR, 1'b0, b, e);
    chk(b[55:0] - a[55:0], 56'h600);
    acc(REFERENCE_ADDR, 1'b1, a, e);
    chk(e, 1'b1);
    acc(REFERENCE_ADDR, 1'b0, a, e);
    chk(a[55:0] - b[55:0], 56'hC00);
    acc(32'hC0010082, 1'b0, a, e);
    chk({e, a}, {1'b1, 64'h0});
    chk(rd_valid, 1'b1);
    acc(REFERENCE_ADDR, 1'b0, a, e);
    clk_en = 1'b0;
    repeat (3) @(negedge clk);
    clk_en = 1'b1;
    acc(REFERENCE_ADDR, 1'b0, b, e);
    chk(b[55:0] - a[55:0], 56'h600);
    for (int k = 0; k < 3; k++)
    begin
      rate = (k == 0) ? 3'h0 : ((k == 1) ? 3'h3 : 3'h7);
      repeat (2) @(negedge clk);
      acc(RETIRED_ADDR, 1'b0, a, e);
      chk(a[63:56], CLASS_FREQ_SENS);
      acc(RETIRED_ADDR, 1'b0, b, e);
      chk(b[55:0] - a[55:0], 56'(rate) * 56'h200);
    end
    results();
  end
endmodule // fsfc_counters_tb_top

/* tb/fsfc_retire_model.sv */
// Retirement-side model that feeds the retired count
`timescale 1ns/10ps
module fsfc_retire_model
  import fsfc_pkg::*;
(
  input  wire logic [fsfc_pkg::RETIRE_W-1:0] rate,
  input  wire logic                          clk,
  input  wire logic                          resetn,
  output logic [fsfc_pkg::RETIRE_W-1:0]      retired_now
);
  // Falling-edge update keeps the count steady at the core's sampling edge
  always @(negedge clk)
    retired_now <= resetn ? rate : '0;
endmodule // fsfc_retire_model
